// File: hw/iwt_pkg.sv
// package for the time base 1 interrupt and wake-up controller
// assumes one 100 MHz core clock and an APB register slave
// Functional notes
// - the time base is cleared and held at zero while its enable bit is 0 and runs at 1; reset 0.
// - select code n gives a period of 2^(8+n) prescaler clocks.
// - control bits 6 to 3 read as zero and ignore writes.
// - any request flag rising wakes sleep or idle, whatever enables say.
// - a set request flag stays set until serviced or cleared by software.
// - entering a service routine pushes only the program counter.
// - return from irq pops pc and sets global enable; plain return leaves it.
// - overflow sets the flag; with enables and room, vector, clear both.
// - source select 00 core clock, 01 core over four, 10/11 slow clock.
package iwt_pkg;
   localparam logic [11:0] IWT_OFF_TBCTL = 12'h000;
   localparam logic [11:0] IWT_OFF_PSRC = 12'h004;
   localparam logic [11:0] IWT_OFF_IRQC = 12'h008;
   localparam logic [11:0] IWT_OFF_STAT = 12'h00C;
   localparam logic [11:0] IWT_OFF_MASK = 12'h010;
   localparam logic [11:0] IWT_OFF_CORE = 12'h014;
   localparam int IWT_TB1_EN_BIT = 7;
   localparam logic [7:0] IWT_TBCTL_RST = 8'h00;
   localparam logic [1:0] IWT_PSRC_RST = 2'h0;
   localparam logic [2:0] IWT_STAT_RST = 3'h0;
   localparam int IWT_BASE_EXP = 8;
   localparam int IWT_CNT_W = 16;
   localparam int IWT_ST_OVF = 0;
   localparam int IWT_ST_WAKE = 1;
   localparam int IWT_ST_VEC = 2;
   localparam int IWT_SYS_DIV = 4;
   localparam int IWT_DIV_W = 2;

   typedef enum logic [1:0] {IWT_RUN, IWT_SLEEP, IWT_IDLE} iwt_mode_e;

   typedef struct packed {
      logic [11:0] paddr;
      logic pwrite;
      logic psel;
      logic penable;
      logic [31:0] pwdata;
   } iwt_apb_req_s;

   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } iwt_apb_rsp_s;

   typedef struct packed {
      logic enter_sleep;
      logic enter_idle;
      logic call_taken;
      logic return_from_irq;
      logic return_plain;
      logic stack_full;
   } iwt_core_s;
endpackage

// File: hw/iwt_tick_gen.sv
// prescaler tick source for the time base
// assumes slow_clock arrives from a pin in another domain
`timescale 1ns/1ps
`default_nettype none
module iwt_tick_gen
   import iwt_pkg::*;
(
   // clock and reset
   input wire logic clock,
   input wire logic rst,
   // control
   input wire logic [1:0] prescaler_source_select,
   input wire logic slow_clock,
   // tick
   output logic tick
);
   typedef struct packed {
      logic [IWT_DIV_W-1:0] div;
      logic [2:0] slow_sync;
      logic tick;
   } iwt_tick_st_s;

   iwt_tick_st_s st_r, st_nxt;

   always_comb begin
      st_nxt = st_r;
      st_nxt.div = st_r.div + 1'b1;
      // first stage feeds second only; edge seen between stages 2 and 3
      st_nxt.slow_sync = {st_r.slow_sync[1:0], slow_clock};
      case (prescaler_source_select)
         2'h0: st_nxt.tick = 1'b1;
         2'h1: st_nxt.tick = (st_r.div == IWT_DIV_W'(IWT_SYS_DIV - 1));
         default: st_nxt.tick = st_r.slow_sync[1] & ~st_r.slow_sync[2];
      endcase
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign tick = st_r.tick;

   a_div_four: assert property (@(posedge clock)
      disable iff (rst)
      tick && $past(prescaler_source_select, 1) == 2'h1
      && $past(prescaler_source_select, 2) == 2'h1
      && $past(prescaler_source_select, 3) == 2'h1
      && $past(prescaler_source_select, 4) == 2'h1
      |-> !$past(tick, 1) && !$past(tick, 2) && !$past(tick, 3))
      else $error("divide by four tick too frequent");
endmodule
`default_nettype wire

// File: hw/iwt_ctrl.sv
// time base 1 interrupt, wake-up and return handling with APB registers
// assumes the core reports calls, returns and sleep entry as pulses
//
// The implementer's own choices: the APB register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module iwt_ctrl
   import iwt_pkg::*;
#(
   parameter int PC_W = 12
) (
   // clock and reset
   input wire logic clock,
   input wire logic rst,
   // apb
   input wire iwt_apb_req_s apb_req,
   output iwt_apb_rsp_s apb_rsp,
   // core side
   input wire iwt_core_s core,
   input wire logic [PC_W-1:0] core_pc,
   input wire logic slow_clock,
   // outputs
   output logic irq,
   output logic vector_req,
   output logic stack_push,
   output logic [PC_W-1:0] stack_push_data,
   output logic stack_pop,
   output logic wake,
   output logic global_irq_enable,
   output logic timebase1_request_flag
);
   typedef struct packed {
      logic timebase1_enable;
      logic [2:0] timebase1_period_select;
      logic [1:0] prescaler_source_select;
      logic timebase1_irq_enable;
      logic global_irq_enable;
      logic timebase1_request_flag;
      logic flag_d;
      logic [IWT_CNT_W-1:0] count;
      iwt_mode_e mode;
      logic [2:0] stat;
      logic [2:0] mask;
      logic irq;
      logic vector_req;
      logic stack_push;
      logic [PC_W-1:0] push_data;
      logic stack_pop;
      logic wake;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } iwt_st_s;

   iwt_st_s st_r, st_nxt;
   logic tick;

   // terminal count for a select code
   function automatic logic [IWT_CNT_W-1:0] period_last(
      input logic [2:0] sel);
      logic [IWT_CNT_W-1:0] one;
      one = IWT_CNT_W'(1);
      period_last = (one << (IWT_BASE_EXP + int'(sel))) - one;
   endfunction

   iwt_tick_gen iwt_tick_gen_inst (
      .clock(clock),
      .rst(rst),
      .prescaler_source_select(st_r.prescaler_source_select),
      .slow_clock(slow_clock),
      .tick(tick)
   );

   logic setup_wr, access, overflow, take, clr_flag, set_flag;
   logic [2:0] w_stat, ev;

   always_comb begin
      st_nxt = st_r;
      access = apb_req.psel & apb_req.penable & ~st_r.pready;
      setup_wr = access & apb_req.pwrite;
      overflow = 1'b0;
      clr_flag = 1'b0;
      w_stat = 3'h0;
      st_nxt.pready = access;
      st_nxt.pslverr = 1'b0;
      st_nxt.vector_req = 1'b0;
      st_nxt.stack_push = 1'b0;
      st_nxt.stack_pop = 1'b0;
      st_nxt.wake = 1'b0;

      // time base counter
      if (!st_r.timebase1_enable) begin
         st_nxt.count = '0;
      end else if (tick) begin
         if (st_r.count >= period_last(st_r.timebase1_period_select)) begin
            st_nxt.count = '0;
            overflow = 1'b1;
         end else begin
            st_nxt.count = st_r.count + 1'b1;
         end
      end

      // interrupt entry
      take = st_r.timebase1_request_flag & st_r.timebase1_irq_enable &
         st_r.global_irq_enable & ~core.stack_full &
         (st_r.mode == IWT_RUN) & ~st_r.vector_req;
      if (take) begin
         st_nxt.vector_req = 1'b1;
         st_nxt.stack_push = 1'b1;
         st_nxt.push_data = core_pc;
         st_nxt.global_irq_enable = 1'b0;
         clr_flag = 1'b1;
      end

      // register writes
      if (setup_wr) begin
         case (apb_req.paddr)
            IWT_OFF_TBCTL: begin
               st_nxt.timebase1_enable = apb_req.pwdata[IWT_TB1_EN_BIT];
               st_nxt.timebase1_period_select = apb_req.pwdata[2:0];
            end // bits 6..3 dropped
            IWT_OFF_PSRC: st_nxt.prescaler_source_select = apb_req.pwdata[1:0];
            IWT_OFF_IRQC: begin
               st_nxt.global_irq_enable = apb_req.pwdata[0];
               st_nxt.timebase1_irq_enable = apb_req.pwdata[1];
               if (apb_req.pwdata[2]) begin
                  st_nxt.timebase1_request_flag = 1'b1;
               end else begin
                  clr_flag = 1'b1;
               end
            end
            IWT_OFF_STAT: w_stat = apb_req.pwdata[2:0];
            IWT_OFF_MASK: st_nxt.mask = apb_req.pwdata[2:0];
            IWT_OFF_CORE: begin
               if (apb_req.pwdata[0]) st_nxt.mode = IWT_SLEEP;
               if (apb_req.pwdata[1]) st_nxt.mode = IWT_IDLE;
            end
            default: st_nxt.pslverr = 1'b1;
         endcase
      end else if (access) begin
         case (apb_req.paddr)
            IWT_OFF_TBCTL, IWT_OFF_PSRC, IWT_OFF_IRQC, IWT_OFF_STAT,
            IWT_OFF_MASK, IWT_OFF_CORE: ;
            default: st_nxt.pslverr = 1'b1;
         endcase
      end

      if (clr_flag) st_nxt.timebase1_request_flag = 1'b0;
      set_flag = overflow;
      if (set_flag) st_nxt.timebase1_request_flag = 1'b1;

      // core pulses
      if (core.enter_sleep) st_nxt.mode = IWT_SLEEP;
      if (core.enter_idle) st_nxt.mode = IWT_IDLE;
      if (core.return_from_irq) begin
         st_nxt.stack_pop = 1'b1;
         st_nxt.global_irq_enable = 1'b1;
      end else if (core.return_plain) begin
         st_nxt.stack_pop = 1'b1;
      end

      // wake from sleep or idle on any rising request flag
      st_nxt.flag_d = st_r.timebase1_request_flag;
      if (st_r.timebase1_request_flag & ~st_r.flag_d &
          (st_r.mode != IWT_RUN)) begin
         st_nxt.wake = 1'b1;
         st_nxt.mode = IWT_RUN;
      end

      // sticky status, set beats clear
      ev = {st_r.vector_req, st_r.wake, overflow};
      st_nxt.stat = (st_r.stat & ~w_stat) | ev;
      st_nxt.irq = |(st_nxt.stat & st_nxt.mask);

      // read data
      st_nxt.prdata = 32'h0000_0000;
      if (access & ~apb_req.pwrite) begin
         case (apb_req.paddr)
            IWT_OFF_TBCTL: st_nxt.prdata = {24'h00_0000,
               st_r.timebase1_enable, 4'h0,
               st_r.timebase1_period_select};
            IWT_OFF_PSRC: st_nxt.prdata = {30'h0,
               st_r.prescaler_source_select};
            IWT_OFF_IRQC: st_nxt.prdata = {29'h0,
               st_r.timebase1_request_flag, st_r.timebase1_irq_enable,
               st_r.global_irq_enable};
            IWT_OFF_STAT: st_nxt.prdata = {29'h0, st_r.stat};
            IWT_OFF_MASK: st_nxt.prdata = {29'h0, st_r.mask};
            IWT_OFF_CORE: st_nxt.prdata = {30'h0, st_r.mode};
            default: st_nxt.prdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         st_r <= '0;
         st_r.timebase1_enable <= IWT_TBCTL_RST[IWT_TB1_EN_BIT];
         st_r.timebase1_period_select <= IWT_TBCTL_RST[2:0];
         st_r.prescaler_source_select <= IWT_PSRC_RST;
         st_r.stat <= IWT_STAT_RST;
         st_r.mode <= IWT_RUN;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign apb_rsp.prdata = st_r.prdata;
   assign apb_rsp.pready = st_r.pready;
   assign apb_rsp.pslverr = st_r.pslverr;
   assign irq = st_r.irq;
   assign vector_req = st_r.vector_req;
   assign stack_push = st_r.stack_push;
   assign stack_push_data = st_r.push_data;
   assign stack_pop = st_r.stack_pop;
   assign wake = st_r.wake;
   assign global_irq_enable = st_r.global_irq_enable;
   assign timebase1_request_flag = st_r.timebase1_request_flag;

   a_off_count_clear: assert property (@(posedge clock)
      disable iff (rst) !st_r.timebase1_enable |=> st_r.count == '0)
      else $error("counter ran while disabled");
   a_count_bound: assert property (@(posedge clock)
      disable iff (rst) st_r.timebase1_enable && tick
      |=> st_r.count <= period_last($past(st_r.timebase1_period_select)))
      else $error("counter beyond selected period");
   a_ctl_read_zero: assert property (@(posedge clock)
      disable iff (rst)
      access && !apb_req.pwrite && apb_req.paddr == IWT_OFF_TBCTL
      |=> apb_rsp.prdata[6:3] == 4'h0)
      else $error("unimplemented bits read nonzero");
   a_wake_on_rise: assert property (@(posedge clock)
      disable iff (rst)
      st_r.mode != IWT_RUN && $rose(st_r.timebase1_request_flag)
      |=> wake && st_r.mode == IWT_RUN)
      else $error("no wake on rising flag");
   a_wake_asleep: assert property (@(posedge clock)
      disable iff (rst) wake |-> $past(st_r.mode) != IWT_RUN)
      else $error("wake pulse while running");
   a_flag_sticky: assert property (@(posedge clock)
      disable iff (rst)
      st_r.timebase1_request_flag && !take && !setup_wr
      |=> st_r.timebase1_request_flag)
      else $error("flag dropped without service");
   a_push_pc: assert property (@(posedge clock)
      disable iff (rst)
      take |=> stack_push && stack_push_data == $past(core_pc))
      else $error("pc not pushed on entry");
   a_irq_ret_sets_en: assert property (@(posedge clock)
      disable iff (rst)
      core.return_from_irq |=> stack_pop && global_irq_enable)
      else $error("return from irq left enable low");
   a_plain_keeps_en: assert property (@(posedge clock)
      disable iff (rst)
      core.return_plain && !core.return_from_irq && !global_irq_enable
      && !setup_wr |=> stack_pop && !global_irq_enable)
      else $error("plain return changed enable");
   a_vector_clears: assert property (@(posedge clock)
      disable iff (rst) take && !core.return_from_irq && !setup_wr
      |=> vector_req && !global_irq_enable)
      else $error("vector did not clear enable");
   a_overflow_flag: assert property (@(posedge clock)
      disable iff (rst) overflow |=> timebase1_request_flag)
      else $error("overflow lost");
   a_overflow_status: assert property (@(posedge clock)
      disable iff (rst) overflow |=> st_r.stat[IWT_ST_OVF])
      else $error("overflow not in status");
   a_ready_one_cycle: assert property (@(posedge clock)
      disable iff (rst) apb_rsp.pready |=> !apb_rsp.pready)
      else $error("pready held longer than one cycle");
   a_irq_follows: assert property (@(posedge clock)
      disable iff (rst) irq == |(st_r.stat & st_r.mask))
      else $error("irq does not follow unmasked status");
endmodule
`default_nettype wire

// File: tb/test_irq_wakeup_timebase_ctrl.sv
// self-checking bench for the time base 1 interrupt and wake-up controller
// assumes iwt_ctrl answers apb with pready and pulses its events
`timescale 1ns/1ps
`default_nettype none
module test_irq_wakeup_timebase_ctrl;
   import iwt_pkg::*;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic slow_clock = 1'b0;
   iwt_apb_req_s req = '0;
   iwt_apb_rsp_s rsp;
   iwt_core_s core = '0;
   logic [11:0] core_pc = 12'h000;
   logic irq, vector_req, stack_push, stack_pop, wake, gie, flag;
   logic [11:0] push_data;
   logic flag_q = 1'b0;
   int err_count = 0;
   int tests_run = 0;
   int cyc = 0, nrise = 0, trise = 0, nvec = 0, npush = 0, npop = 0, nwake = 0;
   logic [31:0] q;
   logic e;
   int t1;

   iwt_ctrl #(.PC_W(12)) iwt_ctrl_inst (
      .clock(clock), .rst(rst), .apb_req(req), .apb_rsp(rsp), .core(core),
      .core_pc(core_pc), .slow_clock(slow_clock), .irq(irq),
      .vector_req(vector_req), .stack_push(stack_push),
      .stack_push_data(push_data), .stack_pop(stack_pop), .wake(wake),
      .global_irq_enable(gie), .timebase1_request_flag(flag));

   always #5 clock = ~clock;
   // slow clock with a period of 8 core clocks
   always @(posedge clock) begin
      if (cyc % 4 == 0) slow_clock <= ~slow_clock;
   end
   // event monitor, looks between edges where outputs are settled
   always @(negedge clock) begin
      cyc++;
      if (!rst) begin
         if (flag === 1'b1 && flag_q === 1'b0) begin
            nrise++;
            trise = cyc;
         end
         flag_q = flag;
         if (vector_req === 1'b1) nvec++;
         if (stack_push === 1'b1) npush++;
         if (stack_pop === 1'b1) npop++;
         if (wake === 1'b1) nwake++;
      end
   end

   task automatic end_sim();
      $display("checks %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic chk(input string name, input logic [31:0] seen,
                      input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic apb(input logic [11:0] a, input logic w,
                      input logic [31:0] d);
      int n;
      @(posedge clock);
      req.paddr <= a;
      req.pwrite <= w;
      req.pwdata <= d;
      req.psel <= 1'b1;
      req.penable <= 1'b0;
      @(posedge clock);
      req.penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (rsp.pready !== 1'b1 && n < 20);
      q = rsp.prdata;
      e = rsp.pslverr;
      if (n >= 20) chk("pready", 1'b0, 1'b1);
      req.psel <= 1'b0;
      req.penable <= 1'b0;
   endtask

   task automatic rd(input string name, input logic [11:0] a,
                     input logic [31:0] exp);
      apb(a, 1'b0, 32'h0000_0000);
      chk(name, q, exp);
   endtask

   task automatic pulse(input iwt_core_s v);
      @(posedge clock);
      core <= v;
      @(posedge clock);
      core <= iwt_core_s'({5'b0_0000, v.stack_full});
   endtask

   task automatic wait_rise();
      int n0, k;
      n0 = nrise;
      k = 0;
      while (nrise == n0 && k < 70000) begin
         @(negedge clock);
         k++;
      end
   endtask

   task automatic period(input logic [1:0] src, input logic [2:0] sel,
                         input int exp);
      apb(IWT_OFF_PSRC, 1'b1, {30'h0, src});
      apb(IWT_OFF_IRQC, 1'b1, 32'h0000_0000);
      apb(IWT_OFF_TBCTL, 1'b1, {24'h0, 5'b1_0000, sel});
      wait_rise();
      t1 = trise;
      apb(IWT_OFF_IRQC, 1'b1, 32'h0000_0000);
      wait_rise();
      chk("period", 32'(trise - t1), 32'(exp));
      apb(IWT_OFF_TBCTL, 1'b1, 32'h0000_0000);
   endtask

   initial begin
      repeat (95000) @(posedge clock);
      err_count++;
      end_sim();
   end

   initial begin
      logic [11:0] offs [6];
      offs = '{IWT_OFF_TBCTL, IWT_OFF_PSRC, IWT_OFF_IRQC, IWT_OFF_STAT,
               IWT_OFF_MASK, IWT_OFF_CORE};
      repeat (8) @(posedge clock);
      rst <= 1'b0;
      foreach (offs[i]) rd("reset value", offs[i], 32'h0000_0000);
      chk("irq idle", irq, 1'b0);
      apb(IWT_OFF_TBCTL, 1'b1, 32'h0000_00FF);
      rd("tb1 control", IWT_OFF_TBCTL, 32'h0000_0087);
      apb(IWT_OFF_TBCTL, 1'b1, 32'h0000_0000);
      rd("unmapped", 12'h020, 32'h0000_0000);
      chk("unmapped err", e, 1'b1);
      // every source and the ends of the select range
      period(2'b00, 3'b000, 256);
      period(2'b00, 3'b001, 512);
      period(2'b01, 3'b000, 1024);
      period(2'b10, 3'b000, 2048);
      period(2'b11, 3'b000, 2048);
      period(2'b00, 3'b111, 32768);
      // flag cleared so a running counter would show a new rise
      apb(IWT_OFF_IRQC, 1'b1, 32'h0000_0000);
      t1 = nrise;
      repeat (600) @(posedge clock);
      chk("disabled rises", 32'(nrise), 32'(t1));
      apb(IWT_OFF_MASK, 1'b1, 32'h0000_0001);
      chk("irq masked in", irq, 1'b1);
      apb(IWT_OFF_MASK, 1'b1, 32'h0000_0000);
      chk("irq masked out", irq, 1'b0);
      apb(IWT_OFF_STAT, 1'b1, 32'h0000_0007);
      rd("status cleared", IWT_OFF_STAT, 32'h0000_0000);
      apb(IWT_OFF_MASK, 1'b1, 32'h0000_0007);
      // flag held with global enable off, then stack full blocks the call
      apb(IWT_OFF_IRQC, 1'b1, 32'h0000_0006);
      repeat (20) @(posedge clock);
      rd("flag sticky", IWT_OFF_IRQC, 32'h0000_0006);
      core_pc <= 12'hABC;
      core.stack_full <= 1'b1;
      apb(IWT_OFF_IRQC, 1'b1, 32'h0000_0007);
      repeat (20) @(posedge clock);
      chk("no call when full", 32'(nvec), 32'h0);
      rd("flag kept", IWT_OFF_IRQC, 32'h0000_0007);
      core.stack_full <= 1'b0;
      repeat (20) @(posedge clock);
      chk("call taken", 32'(nvec), 32'h1);
      chk("one push", 32'(npush), 32'h1);
      chk("pushed pc", push_data, 12'hABC);
      rd("after call", IWT_OFF_IRQC, 32'h0000_0002);
      chk("irq vector", irq, 1'b1);
      apb(IWT_OFF_STAT, 1'b1, 32'h0000_0007);
      chk("irq cleared", irq, 1'b0);
      pulse(iwt_core_s'(6'b00_0010)); // plain return pops but leaves global enable off
      repeat (3) @(posedge clock);
      chk("plain pop", 32'(npop), 32'h1);
      chk("plain gie", gie, 1'b0);
      pulse(iwt_core_s'(6'b00_0100));
      repeat (3) @(posedge clock);
      chk("irq return pop", 32'(npop), 32'h2);
      chk("irq return gie", gie, 1'b1);
      // flag set beforehand keeps the overflow from waking sleep
      apb(IWT_OFF_IRQC, 1'b1, 32'h0000_0004);
      apb(IWT_OFF_CORE, 1'b1, 32'h0000_0001);
      rd("sleep mode", IWT_OFF_CORE, 32'h0000_0001);
      apb(IWT_OFF_TBCTL, 1'b1, 32'h0000_0080);
      repeat (600) @(posedge clock);
      chk("no wake", 32'(nwake), 32'h0);
      apb(IWT_OFF_IRQC, 1'b1, 32'h0000_0000);
      repeat (300) @(posedge clock);
      chk("overflow wake", 32'(nwake), 32'h1);
      apb(IWT_OFF_TBCTL, 1'b1, 32'h0000_0000);
      // flag low again so the idle test sees a fresh rise
      apb(IWT_OFF_IRQC, 1'b1, 32'h0000_0000);
      rd("woken mode", IWT_OFF_CORE, 32'h0000_0000);
      pulse(iwt_core_s'(6'b01_0000));
      rd("idle mode", IWT_OFF_CORE, 32'h0000_0002);
      apb(IWT_OFF_IRQC, 1'b1, 32'h0000_0004);
      repeat (5) @(posedge clock);
      chk("flag wake", 32'(nwake), 32'h2);
      rd("run again", IWT_OFF_CORE, 32'h0000_0000);
      rd("wake status", IWT_OFF_STAT, 32'h0000_0003);
      end_sim();
   end
endmodule
`default_nettype wire
